// ==== hdl/reset_sequencer_pin_mux.sv ====
// reset sequencer, pin function keys and clock trim for the small controller
// Overview of operation
// - accept pin, supply and watchdog reset requests
// - illegal opcode or prebyte also requests reset
// - internal sources drive pin; low through delay
// - start address from vector FFFE/FFFF
// - phases: active, counted delay, vector fetch
// - vector fetch lasts exactly two cycles
// - delay 512 clocks fast/external, 256 slow
// - pin low detected without a clock
// - watchdog underflow holds pin low minimum time
// - both key bytes readable, written once per reset
// - keys cleared on power-up and internal reset; zero keeps reset pin
// - 55h then AAh turns pin into output
// - software cannot restore reset function if both key bytes were written since the last reset
// - internal reset clears keys, restores reset pin
// - supply reset uses rising/falling thresholds
// - supply reset keeps pin driven low
// - option disables supply reset requests
// - supply reset wins, clears watchdog flag
// - trim is high byte plus low bits 6:5
// - supply reset sets flag; read clears it
`timescale 1ns/1ps
module reset_sequencer_pin_mux
	import rst_seq_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	input  wire logic        RST_PIN_I,
	output logic             RST_PIN_O,
	output logic             RST_PIN_OE,
	input  wire logic        VDD_BELOW_RISE,
	input  wire logic        VDD_BELOW_FALL,
	input  wire logic        LVD_OPTION_EN,
	input  wire logic [1:0]  CLOCK_SOURCE_SEL,
	input  wire logic        WATCHDOG_UNDERFLOW,
	input  wire logic        ILLEGAL_OPCODE,
	input  wire logic        ILLEGAL_PREBYTE,
	output logic             CPU_RESET,
	output logic             VECTOR_FETCH,
	output logic [15:0]      VECTOR_ADDR,
	output logic             PORT_A3_OUTPUT_MODE,
	output logic [9:0]       RC_TRIM,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP
);

	// byte address of a register index
	function automatic logic [31:0] reg_addr(input logic [7:0] idx);
		reg_addr = {22'h00_0000, idx, 2'b00};
	endfunction : reg_addr

	seq_state_t  state_reg;            // sequencer phase
	seq_state_t  state_next;           // next phase
	reset_src_t  src;                  // live reset requests
	logic        any_src;              // some request active
	logic        internal_src;         // request from inside the chip
	logic        ext_catch_reg;        // pin low caught without clock
	logic        ext_sync1_reg;        // first synchroniser stage
	logic        ext_sync2_reg;        // second synchroniser stage
	logic [2:0]  drive_hist_reg;       // recent own pin drive
	logic        powered_reg;          // supply has passed rising threshold
	logic [7:0]  pulse_cnt_reg;        // minimum pulse countdown
	logic        pulse_busy;           // minimum pulse still running
	logic [9:0]  delay_cnt_reg;        // delay phase counter
	logic [9:0]  delay_last;           // final count of the delay
	logic        fetch_cnt_reg;        // vector fetch cycle index
	logic        seq_start;            // a new reset sequence begins
	logic [7:0]  key_low_reg;          // pin function key, low byte
	logic [7:0]  key_high_reg;         // pin function key, high byte
	logic [7:0]  key_low_next;         // next low key byte
	logic [7:0]  key_high_next;        // next high key byte
	logic        key_low_wr_reg;       // low byte already written
	logic        key_high_wr_reg;      // high byte already written
	logic [7:0]  trim_high_reg;        // oscillator trim high byte
	logic [1:0]  trim_low_reg;         // oscillator trim low bits
	logic [7:0]  trim_high_next;       // next trim high byte
	logic [1:0]  trim_low_next;        // next trim low bits
	logic        lvd_flag_reg;         // supply drop reset flag
	logic        wdg_flag_reg;         // watchdog reset flag
	logic        dp_valid_reg;         // bus data phase pending
	logic        dp_write_reg;         // pending phase is a write
	logic [31:0] dp_addr_reg;          // pending phase address
	logic        ap_take;              // address phase accepted
	logic        rd_trim_low;          // read of trim low this cycle
	logic        rd_status;            // read of status this cycle
	logic        port_mode;            // keys hold the unlock pattern
	logic [7:0]  rd_data;              // read data for the address phase

	// key pattern selects port function; power-up, an internal reset or a write to a key byte not written since the last reset reverses it
	assign port_mode = (key_low_reg == KEY_LOW_UNLOCK) &&
		(key_high_reg == KEY_HIGH_UNLOCK);

	// pin low sets the catch flop with no clock needed
	always_ff @(posedge CLK_SYS or negedge RST_PIN_I) begin
		if (!RST_PIN_I) begin
			ext_catch_reg <= 1'b1;
		end else if (RESET) begin
			ext_catch_reg <= 1'b0;
		end else begin
			ext_catch_reg <= 1'b0;
		end
	end

	// two-stage synchroniser for the caught pin level
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ext_sync1_reg <= 1'b0;
			ext_sync2_reg <= 1'b0;
		end else begin
			ext_sync1_reg <= ext_catch_reg;
			ext_sync2_reg <= ext_sync1_reg;
		end
	end

	// history of own drive so our own low is not seen as a request
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			drive_hist_reg <= 3'b000;
		end else begin
			drive_hist_reg <= {drive_hist_reg[1:0], RST_PIN_OE};
		end
	end

	// supply threshold with hysteresis
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			powered_reg <= 1'b0;
		end else if (!powered_reg && !VDD_BELOW_RISE) begin
			powered_reg <= 1'b1;
		end else if (powered_reg && VDD_BELOW_FALL) begin
			powered_reg <= 1'b0;
		end
	end

	// gather all reset requests
	always_comb begin
		src.ext = ext_sync2_reg && !port_mode && !RST_PIN_OE &&
			(drive_hist_reg == 3'b000);
		src.low_supply_detector = LVD_OPTION_EN && (powered_reg ? VDD_BELOW_FALL
			: VDD_BELOW_RISE);
		src.wdg = WATCHDOG_UNDERFLOW;
		src.ill = ILLEGAL_OPCODE || ILLEGAL_PREBYTE;
	end
	assign any_src      = src.ext || src.low_supply_detector || src.wdg || src.ill;
	assign internal_src = src.low_supply_detector || src.wdg || src.ill;
	assign seq_start    = (state_reg == ST_RUN) && any_src;
	assign pulse_busy   = (pulse_cnt_reg != 8'h00);

	// delay length from the clock source option
	assign delay_last = (CLOCK_SOURCE_SEL == CLKSRC_RC_SLOW)
		? 10'(DELAY_SHORT_CYC - 1) : 10'(DELAY_LONG_CYC - 1);

	// phase sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (any_src) begin
					state_next = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (!any_src && !pulse_busy) begin
					state_next = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (any_src) begin
					state_next = ST_ACTIVE;
				end else if (delay_cnt_reg == delay_last) begin
					state_next = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (any_src) begin
					state_next = ST_ACTIVE;
				end else if (fetch_cnt_reg) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_ACTIVE;
			end
		endcase
	end

	// phase register; power-up enters the active phase
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state_reg <= ST_ACTIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	// minimum pulse for watchdog and illegal code, from the event
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pulse_cnt_reg <= 8'h00;
		end else if (src.wdg || src.ill) begin
			pulse_cnt_reg <= 8'(WDG_PULSE_CYC);
		end else if (pulse_busy) begin
			pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
		end
	end

	// delay counter, held at zero while any request is active
	always_ff @(posedge CLK_SYS) begin
		if (RESET || state_reg != ST_DELAY || any_src) begin
			delay_cnt_reg <= 10'h000;
		end else begin
			delay_cnt_reg <= delay_cnt_reg + 10'h001;
		end
	end

	// vector fetch cycle index
	always_ff @(posedge CLK_SYS) begin
		if (RESET || state_reg != ST_FETCH) begin
			fetch_cnt_reg <= 1'b0;
		end else begin
			fetch_cnt_reg <= 1'b1;
		end
	end

	// sequencer outputs, all registered
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			CPU_RESET    <= 1'b1;
			RST_PIN_O    <= 1'b0;
			RST_PIN_OE   <= 1'b1;
			VECTOR_FETCH <= 1'b0;
			VECTOR_ADDR  <= VECTOR_LOW_ADDR;
		end else begin
			CPU_RESET    <= (state_next == ST_ACTIVE) ||
				(state_next == ST_DELAY);
			RST_PIN_O    <= 1'b0;
			// internal sources and the delay phase pull the pin low
			// an internal source drives at once, though keys clear late
			RST_PIN_OE   <= (!port_mode || internal_src) &&
				((state_next == ST_DELAY) ||
				((state_next == ST_ACTIVE) && (internal_src ||
				pulse_busy)));
			VECTOR_FETCH <= (state_next == ST_FETCH);
			VECTOR_ADDR  <= (state_next == ST_FETCH && state_reg == ST_FETCH)
				? VECTOR_HIGH_ADDR : VECTOR_LOW_ADDR;
		end
	end

	// bus address phase capture
	assign ap_take = HSEL && HTRANS[1] && HREADY;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg  <= 32'h0000_0000;
		end else begin
			dp_valid_reg <= ap_take;
			dp_write_reg <= ap_take && HWRITE;
			dp_addr_reg  <= ap_take ? HADDR : dp_addr_reg;
		end
	end

	// next key and trim values, also used as read bypass
	always_comb begin
		key_low_next   = key_low_reg;
		key_high_next  = key_high_reg;
		trim_high_next = trim_high_reg;
		trim_low_next  = trim_low_reg;
		if (dp_write_reg) begin
			if (dp_addr_reg == reg_addr(KEY_LOW_IDX) && !key_low_wr_reg) begin
				key_low_next = HWDATA[7:0];
			end
			if (dp_addr_reg == reg_addr(KEY_HIGH_IDX) && !key_high_wr_reg)
			begin
				key_high_next = HWDATA[7:0];
			end
			if (dp_addr_reg == reg_addr(TRIM_HIGH_IDX)) begin
				trim_high_next = HWDATA[7:0];
			end
			if (dp_addr_reg == reg_addr(TRIM_LOW_IDX)) begin
				trim_low_next = HWDATA[TRIM_LOW_CR_HI:TRIM_LOW_CR_LO];
			end
		end
	end

	// pin function keys: written once, cleared by internal resets
	always_ff @(posedge CLK_SYS) begin
		// any internal request clears, also one arriving mid-sequence
		if (RESET || internal_src) begin
			key_low_reg  <= KEY_RESET;
			key_high_reg <= KEY_RESET;
		end else begin
			key_low_reg  <= key_low_next;
			key_high_reg <= key_high_next;
		end
	end

	// write-once marks, rearmed by every reset event
	always_ff @(posedge CLK_SYS) begin
		if (RESET || seq_start) begin
			key_low_wr_reg  <= 1'b0;
			key_high_wr_reg <= 1'b0;
		end else if (dp_write_reg) begin
			key_low_wr_reg  <= key_low_wr_reg ||
				(dp_addr_reg == reg_addr(KEY_LOW_IDX));
			key_high_wr_reg <= key_high_wr_reg ||
				(dp_addr_reg == reg_addr(KEY_HIGH_IDX));
		end
	end

	// oscillator trim, back to default on any reset event
	always_ff @(posedge CLK_SYS) begin
		if (RESET || seq_start) begin
			trim_high_reg <= TRIM_HIGH_RESET;
			trim_low_reg  <= TRIM_LOW_RESET[TRIM_LOW_CR_HI:TRIM_LOW_CR_LO];
		end else begin
			trim_high_reg <= trim_high_next;
			trim_low_reg  <= trim_low_next;
		end
	end

	// reads that clear flags
	assign rd_trim_low = ap_take && !HWRITE &&
		(HADDR == reg_addr(TRIM_LOW_IDX));
	assign rd_status   = ap_take && !HWRITE &&
		(HADDR == reg_addr(SEQ_STATUS_IDX));

	// supply drop flag: set by supply reset, set wins over read clear
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			lvd_flag_reg <= 1'b0;
		end else if (src.low_supply_detector) begin
			lvd_flag_reg <= 1'b1;
		end else if (rd_trim_low) begin
			lvd_flag_reg <= 1'b0;
		end
	end

	// watchdog flag: supply reset clears it, read clears it
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			wdg_flag_reg <= 1'b0;
		end else if (src.low_supply_detector) begin
			wdg_flag_reg <= 1'b0;
		end else if (src.wdg) begin
			wdg_flag_reg <= 1'b1;
		end else if (rd_status) begin
			wdg_flag_reg <= 1'b0;
		end
	end

	// read mux; unmapped reads return zero
	always_comb begin
		rd_data = 8'h00;
		case (HADDR)
			reg_addr(KEY_LOW_IDX): begin
				rd_data = key_low_next;
			end
			reg_addr(KEY_HIGH_IDX): begin
				rd_data = key_high_next;
			end
			reg_addr(TRIM_HIGH_IDX): begin
				rd_data = trim_high_next;
			end
			reg_addr(TRIM_LOW_IDX): begin
				rd_data[TRIM_LOW_CR_HI:TRIM_LOW_CR_LO] = trim_low_next;
				rd_data[TRIM_LOW_FLAG_BIT] = lvd_flag_reg;
			end
			reg_addr(SEQ_STATUS_IDX): begin
				rd_data[STAT_WDG_BIT]  = wdg_flag_reg;
				rd_data[STAT_PORT_BIT] = port_mode;
				rd_data[STAT_BUSY_BIT] = (state_reg != ST_RUN);
			end
			default: begin
				rd_data = 8'h00;
			end
		endcase
	end

	// bus answer: zero wait states, always OKAY
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			HRDATA    <= (ap_take && !HWRITE) ? {24'h00_0000, rd_data}
				: 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// pin function and trim outputs
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			PORT_A3_OUTPUT_MODE <= 1'b0;
			RC_TRIM             <= {TRIM_HIGH_RESET,
				TRIM_LOW_RESET[TRIM_LOW_CR_HI:TRIM_LOW_CR_LO]};
		end else begin
			PORT_A3_OUTPUT_MODE <= port_mode;
			RC_TRIM             <= {trim_high_reg, trim_low_reg};
		end
	end

endmodule : reset_sequencer_pin_mux

// ==== pkg/rst_seq_pkg.sv ====
// constants and types shared by the reset sequencer and pin multiplexer
package rst_seq_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0]  KEY_LOW_IDX       = 8'h47;
	localparam logic [7:0]  KEY_HIGH_IDX      = 8'h48;
	localparam logic [7:0]  TRIM_HIGH_IDX     = 8'h3B;
	localparam logic [7:0]  TRIM_LOW_IDX      = 8'h3C;
	localparam logic [7:0]  SEQ_STATUS_IDX    = 8'h49;

	// reset values
	localparam logic [7:0]  KEY_RESET         = 8'h00;
	localparam logic [7:0]  TRIM_HIGH_RESET   = 8'hFF;
	localparam logic [7:0]  TRIM_LOW_RESET    = 8'h00;

	// key pattern that hands the shared pin to the port
	localparam logic [7:0]  KEY_LOW_UNLOCK    = 8'h55;
	localparam logic [7:0]  KEY_HIGH_UNLOCK   = 8'hAA;

	// trim low field positions
	localparam int          TRIM_LOW_CR_HI    = 6;
	localparam int          TRIM_LOW_CR_LO    = 5;
	localparam int          TRIM_LOW_FLAG_BIT = 2;

	// status register field positions
	localparam int          STAT_WDG_BIT      = 0;
	localparam int          STAT_PORT_BIT     = 1;
	localparam int          STAT_BUSY_BIT     = 2;

	// clock source option codes
	localparam logic [1:0]  CLKSRC_RC_FAST    = 2'b00;
	localparam logic [1:0]  CLKSRC_RC_SLOW    = 2'b01;
	localparam logic [1:0]  CLKSRC_EXT        = 2'b10;

	// timing
	localparam int          CLK_FREQ_MHZ      = 10;
	localparam int          DELAY_LONG_CYC    = 512;
	localparam int          DELAY_SHORT_CYC   = 256;
	localparam int          FETCH_CYC         = 2;
	localparam int          WDG_PULSE_NS      = 20000;
	localparam int          WDG_PULSE_CYC     =
		(WDG_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;

	// fixed reset vector pair
	localparam logic [15:0] VECTOR_LOW_ADDR   = 16'hFFFE;
	localparam logic [15:0] VECTOR_HIGH_ADDR  = 16'hFFFF;

	// reset requests gathered from every source
	typedef struct packed {
		logic ext;
		logic low_supply_detector;
		logic wdg;
		logic ill;
	} reset_src_t;

	// sequencer phases, one-hot
	typedef enum logic [3:0] {
		ST_RUN    = 4'b0001,
		ST_ACTIVE = 4'b0010,
		ST_DELAY  = 4'b0100,
		ST_FETCH  = 4'b1000
	} seq_state_t;

endpackage : rst_seq_pkg

// ==== test/ext_reset_circuit.sv ====
// model of the outside circuit sharing the open-drain reset pin
`timescale 1ns/1ps
module ext_reset_circuit (
	input  wire logic pin_oe,    // device pulls the pin
	input  wire logic pin_o,     // device output value
	input  wire logic pull_low,  // outside circuit requests reset
	output logic      pin_level  // resolved pin level
);
	// wired-and with pull-up: any party pulling low wins
	assign pin_level = !((pin_oe && !pin_o) || pull_low);
endmodule : ext_reset_circuit

// ==== test/reset_sequencer_pin_mux_asserts.sv ====
// port assertions for the reset sequencer and pin multiplexer
`timescale 1ns/1ps
module rst_seq_checker
	import rst_seq_pkg::*;
(
	input wire logic        CLK_SYS,
	input wire logic        RESET,
	input wire logic        RST_PIN_I,
	input wire logic        RST_PIN_O,
	input wire logic        RST_PIN_OE,
	input wire logic        VDD_BELOW_RISE,
	input wire logic        VDD_BELOW_FALL,
	input wire logic        LVD_OPTION_EN,
	input wire logic [1:0]  CLOCK_SOURCE_SEL,
	input wire logic        WATCHDOG_UNDERFLOW,
	input wire logic        ILLEGAL_OPCODE,
	input wire logic        ILLEGAL_PREBYTE,
	input wire logic        CPU_RESET,
	input wire logic        VECTOR_FETCH,
	input wire logic [15:0] VECTOR_ADDR,
	input wire logic        PORT_A3_OUTPUT_MODE,
	input wire logic        HREADYOUT,
	input wire logic        HRESP
);
	logic       src_q;     // sources that surely reset
	logic       int_src;   // any internal source
	logic [9:0] quiet_cnt; // cycles since last sure source
	logic [7:0] wdg_cnt;   // cycles since last underflow
	int         dly_min;   // delay length for the clock source
	assign src_q = WATCHDOG_UNDERFLOW | ILLEGAL_OPCODE | ILLEGAL_PREBYTE
		| (LVD_OPTION_EN & VDD_BELOW_FALL)
		| (!RST_PIN_I & !RST_PIN_OE & !PORT_A3_OUTPUT_MODE);
	assign int_src = WATCHDOG_UNDERFLOW | ILLEGAL_OPCODE | ILLEGAL_PREBYTE
		| (LVD_OPTION_EN & (VDD_BELOW_RISE | VDD_BELOW_FALL));
	assign dly_min = (CLOCK_SOURCE_SEL == CLKSRC_RC_SLOW) ?
		DELAY_SHORT_CYC : DELAY_LONG_CYC;
	// saturating count of quiet cycles
	always_ff @(posedge CLK_SYS) begin
		if (RESET || src_q)
			quiet_cnt <= 10'h000;
		else if (quiet_cnt != 10'h3FF)
			quiet_cnt <= quiet_cnt + 10'h001;
	end
	// saturating count since the watchdog fired
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			wdg_cnt <= 8'hFF;
		else if (WATCHDOG_UNDERFLOW)
			wdg_cnt <= 8'h00;
		else if (wdg_cnt != 8'hFF)
			wdg_cnt <= wdg_cnt + 8'h01;
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	a_wdg_starts_reset: assert property (WATCHDOG_UNDERFLOW |=>
		CPU_RESET && RST_PIN_OE) else $error("watchdog reset missing");
	a_illegal_starts: assert property ((ILLEGAL_OPCODE ||
		ILLEGAL_PREBYTE) |=> CPU_RESET && RST_PIN_OE)
		else $error("illegal code reset missing");
	a_wdg_pulse_min: assert property ((wdg_cnt >= 1 &&
		wdg_cnt <= WDG_PULSE_CYC) |-> RST_PIN_OE)
		else $error("watchdog pin pulse too short");
	a_supply_pin_low: assert property (LVD_OPTION_EN &&
		VDD_BELOW_FALL |=> RST_PIN_OE) else $error("supply pin not low");
	a_fetch_two: assert property ($rose(VECTOR_FETCH) |=>
		VECTOR_FETCH ##1 !VECTOR_FETCH) else $error("fetch length wrong");
	a_vector_pair: assert property ($rose(VECTOR_FETCH) |->
		VECTOR_ADDR == VECTOR_LOW_ADDR ##1 VECTOR_ADDR == VECTOR_HIGH_ADDR)
		else $error("vector address wrong");
	a_delay_floor: assert property ($rose(VECTOR_FETCH) |->
		quiet_cnt >= dly_min && $past(RST_PIN_OE))
		else $error("delay too short or pin released");
	a_port_sticky: assert property ($fell(PORT_A3_OUTPUT_MODE) |->
		$past(int_src) || $past(int_src, 2) || $past(int_src, 3))
		else $error("port mode left without internal reset");
	a_pin_drive_low: assert property (RST_PIN_OE |-> !RST_PIN_O)
		else $error("pin driven high");
	a_pin_request: assert property (!RST_PIN_I && !RST_PIN_OE &&
		!PORT_A3_OUTPUT_MODE |-> ##[0:4] CPU_RESET)
		else $error("pin request ignored");
	a_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus not ready or error");
endmodule : rst_seq_checker
bind reset_sequencer_pin_mux rst_seq_checker chk (.*);

// ==== test/reset_sequencer_pin_mux_bench.sv ====
// register-level bench for the reset sequencer and pin multiplexer
`timescale 1ns/1ps
module reset_sequencer_pin_mux_bench
	import rst_seq_pkg::*;
;
	logic        CLK_SYS            = 1'h0;
	logic        RESET              = 1'h1;
	logic        pull_low           = 1'h0; // outside reset request
	logic        VDD_BELOW_RISE     = 1'h0;
	logic        VDD_BELOW_FALL     = 1'h0;
	logic        LVD_OPTION_EN      = 1'h1;
	logic [1:0]  CLOCK_SOURCE_SEL   = CLKSRC_RC_FAST;
	logic        WATCHDOG_UNDERFLOW = 1'h0;
	logic        ILLEGAL_OPCODE     = 1'h0;
	logic        ILLEGAL_PREBYTE    = 1'h0;
	logic        HSEL               = 1'h0;
	logic [31:0] HADDR              = 32'h0000_0000;
	logic [1:0]  HTRANS             = 2'h0;
	logic        HWRITE             = 1'h0;
	logic [2:0]  HSIZE              = 3'h2; // whole words only
	logic [31:0] HWDATA             = 32'h0000_0000;
	logic        HREADY;
	logic        RST_PIN_I, RST_PIN_O, RST_PIN_OE, CPU_RESET, VECTOR_FETCH;
	logic        PORT_A3_OUTPUT_MODE, HREADYOUT, HRESP;
	logic [15:0] VECTOR_ADDR;
	logic [9:0]  RC_TRIM;
	logic [31:0] HRDATA, rdat;
	int          num_errors         = 0;
	int          n_checks           = 0;
	assign HREADY = HREADYOUT; // single slave
	reset_sequencer_pin_mux dut (.*);
	ext_reset_circuit ext (.pin_oe(RST_PIN_OE), .pin_o(RST_PIN_O),
		.pull_low(pull_low), .pin_level(RST_PIN_I));
	always #50 CLK_SYS = ~CLK_SYS; // even duty clock
	// compare a register or bus value
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	// compare a flag
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask : cyc
	// one single transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd);
		HSEL   <= 1'h1;
		HADDR  <= {22'h0, idx, 2'h0};
		HTRANS <= 2'h2;
		HWRITE <= wr;
		do @(posedge CLK_SYS); while (HREADY !== 1'h1);
		HSEL   <= 1'h0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge CLK_SYS); while (HREADY !== 1'h1);
		rdat = HRDATA;
	endtask : bus
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'h1, idx, {24'h0, d});
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'h0, idx, 32'h0000_0000);
		chk_reg(rdat, {24'h0, exp});
	endtask : reg_rd
	// raise one source: 0 watchdog, 1 opcode, 2 prebyte, 3 pin
	task automatic fire(input int src);
		WATCHDOG_UNDERFLOW <= (src == 0);
		ILLEGAL_OPCODE     <= (src == 1);
		ILLEGAL_PREBYTE    <= (src == 2);
		pull_low           <= (src == 3);
		cyc((src == 3) ? 10 : 1);
		WATCHDOG_UNDERFLOW <= 1'h0;
		ILLEGAL_OPCODE     <= 1'h0;
		ILLEGAL_PREBYTE    <= 1'h0;
		pull_low           <= 1'h0;
	endtask : fire
	// count cycles to the vector fetch, then check the fetch
	task automatic boot(input int lo);
		int   n;
		logic oe_ok;
		n = 0;
		oe_ok = 1'h1;
		while (VECTOR_FETCH !== 1'h1 && n < 3000) begin
			@(posedge CLK_SYS);
			n++;
			if (n > 8 && VECTOR_FETCH !== 1'h1 && RST_PIN_OE !== 1'h1)
				oe_ok = 1'h0;
		end
		chk_bit(oe_ok, 1'h1);
		chk_bit(n >= lo - 2 && n <= lo + 8, 1'h1);
		chk_reg({16'h0, VECTOR_ADDR}, 32'h0000_FFFE);
		@(posedge CLK_SYS);
		chk_reg({15'h0, VECTOR_FETCH, VECTOR_ADDR}, 32'h0001_FFFF);
		@(posedge CLK_SYS);
		chk_bit(VECTOR_FETCH | CPU_RESET, 1'h0);
	endtask : boot
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// hang guard, far beyond the expected few thousand cycles
	initial begin
		cyc(20000);
		num_errors++;
		$display("ERROR %0t run did not finish", $time);
		tally_and_finish;
	end
	// main sequence
	initial begin
		cyc(8);
		RESET <= 1'h0;
		boot(DELAY_LONG_CYC + 1);
		reg_rd(KEY_LOW_IDX, KEY_RESET);
		reg_rd(KEY_HIGH_IDX, KEY_RESET);
		chk_reg({22'h0, RC_TRIM}, 32'h0000_03FC);
		reg_wr(TRIM_HIGH_IDX, 8'h5A);
		reg_wr(TRIM_LOW_IDX, 8'h60);
		reg_rd(TRIM_HIGH_IDX, 8'h5A);
		chk_reg({22'h0, RC_TRIM}, 32'h0000_016B);
		reg_wr(8'h50, 8'hA5);
		reg_rd(8'h50, 8'h00);
		$display("test power reset done");
		reg_wr(KEY_LOW_IDX, 8'h12);
		reg_wr(KEY_LOW_IDX, KEY_LOW_UNLOCK);
		reg_rd(KEY_LOW_IDX, 8'h12);
		CLOCK_SOURCE_SEL <= CLKSRC_RC_SLOW;
		fire(3);
		boot(DELAY_SHORT_CYC + 3);
		reg_rd(KEY_LOW_IDX, 8'h12);
		reg_wr(KEY_LOW_IDX, KEY_LOW_UNLOCK);
		reg_rd(KEY_LOW_IDX, KEY_LOW_UNLOCK);
		reg_wr(KEY_HIGH_IDX, KEY_HIGH_UNLOCK);
		cyc(2);
		chk_bit(PORT_A3_OUTPUT_MODE, 1'h1);
		reg_wr(KEY_HIGH_IDX, 8'h00);
		fire(3);
		cyc(3);
		chk_bit(CPU_RESET, 1'h0);
		chk_bit(PORT_A3_OUTPUT_MODE, 1'h1);
		reg_rd(KEY_HIGH_IDX, KEY_HIGH_UNLOCK);
		$display("test pin keys done");
		// watchdog, opcode and prebyte each clear the keys, one clock source each
		for (int s = 0; s < 3; s++) begin
			reg_wr(KEY_LOW_IDX, KEY_LOW_UNLOCK);
			reg_wr(KEY_HIGH_IDX, KEY_HIGH_UNLOCK);
			CLOCK_SOURCE_SEL <= (s == 0) ? CLKSRC_RC_FAST :
				(s == 1) ? CLKSRC_EXT : CLKSRC_RC_SLOW;
			fire(s);
			boot(WDG_PULSE_CYC + ((s == 2) ? 256 : 512));
			chk_bit(PORT_A3_OUTPUT_MODE, 1'h0);
			reg_rd(KEY_LOW_IDX, KEY_RESET);
			reg_rd(KEY_HIGH_IDX, KEY_RESET);
			if (s == 0)
				reg_rd(SEQ_STATUS_IDX, 8'h01);
		end
		$display("test internal sources done");
		CLOCK_SOURCE_SEL <= CLKSRC_RC_FAST;
		LVD_OPTION_EN    <= 1'h0;
		VDD_BELOW_RISE   <= 1'h1;
		VDD_BELOW_FALL   <= 1'h1;
		cyc(20);
		chk_bit(CPU_RESET, 1'h0);
		fire(0);
		cyc(5);
		LVD_OPTION_EN <= 1'h1;
		cyc(200);
		chk_bit(RST_PIN_OE, 1'h1);
		VDD_BELOW_FALL <= 1'h0;
		cyc(10);
		chk_bit(CPU_RESET & RST_PIN_OE, 1'h1);
		VDD_BELOW_RISE <= 1'h0;
		boot(DELAY_LONG_CYC + 1);
		reg_rd(SEQ_STATUS_IDX, 8'h00);
		reg_rd(TRIM_LOW_IDX, 8'h04);
		reg_rd(TRIM_LOW_IDX, 8'h00);
		VDD_BELOW_RISE <= 1'h1;
		cyc(20);
		chk_bit(CPU_RESET, 1'h0);
		VDD_BELOW_RISE <= 1'h0;
		$display("test supply done");
		tally_and_finish;
	end
endmodule : reset_sequencer_pin_mux_bench
